// >>> hw/rtc_pm_pkg.sv
// constants, field layout and state codes of the rtc power management block
// What this block does
// R1: upper bits 15:5 read fixed, ignore writes
// R2: wake output bit 0 pulls low, 1 releases
// R3: direction bit 0 input, 1 output
// R4: input active high; output open-drain pulls low
// R5: wake pin wakes only when direction is input
// R6: full power-down stops regulators, reset and reference
// R7: full power-down ends on wake high or alarm
// R8: regulator power-down keeps the reference running
// R9: regulator power-down ends on wake or alarm
// R10: software avoids power-down with regulators bypassed
// R11: clock-out bit gates the rtc clock output
// R12: any power-down holds power valid low
// R13: writes land two rtc cycles later, need oscillator
package rtc_pm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] PM_REG_ADDR     = 16'h1930;
  localparam logic [15:0] STATUS_REG_ADDR = 16'h1934;
  localparam logic [15:0] PM_RESET        = 16'h0000;
  localparam logic [15:0] PM_RW_MASK      = 16'h001F;
  localparam int          PM_BITS         = 5;

  // ----------------------------------------------------------------
  // power management fields
  // ----------------------------------------------------------------
  localparam int CLKOUT_BIT  = 0;
  localparam int REG_PD_BIT  = 1;
  localparam int FULL_PD_BIT = 2;
  localparam int DIR_BIT     = 3;
  localparam int DOUT_BIT    = 4;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ST_WAKE_BIT  = 0;
  localparam int ST_PEND_BIT  = 1;
  localparam int ST_DOWN_BIT  = 2;
  localparam int ST_VALID_BIT = 3;
  localparam int ST_OSC_BIT   = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [1:0] RTC_EDGES_TO_COMMIT = 2'h2;
  localparam int CLK_MHZ         = 200;
  localparam int BG_SETTLE_MS    = 100;
  localparam int BG_SETTLE_CYCLES = BG_SETTLE_MS * CLK_MHZ * 1000;
  localparam int REG_SETTLE_CYCLES = 16;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_DOWN = 3'b010,
    ST_RAMP = 3'b100
  } pm_state_e;

endpackage : rtc_pm_pkg

// >>> hw/rtc_power_management_ctrl.sv
// apb-reached power management control for the always-on rtc domain
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
module rtc_power_management_ctrl #(
  parameter int BG_SETTLE  = rtc_pm_pkg::BG_SETTLE_CYCLES,
  parameter int REG_SETTLE = rtc_pm_pkg::REG_SETTLE_CYCLES
) (
  input  wire logic        pclk,          // 200 MHz bus clock
  input  wire logic        presetn,       // async reset, active low
  input  wire logic [15:0] paddr,         // apb byte address
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error
  input  wire logic        rtc_clk,       // 32.768 kHz rtc clock, sampled
  input  wire logic        osc_enabled,   // rtc oscillator running
  input  wire logic        alarm_irq,     // rtc alarm interrupt
  input  wire logic        wake_pin_i,    // wake pin level
  output logic             wake_pin_o,    // wake pin drive value
  output logic             wake_pin_oe,   // wake pin drive enable
  output logic             rtc_clk_out,   // gated rtc clock out
  output logic             regulator_en,  // on-chip regulators on
  output logic             analog_por_en, // analog power-on reset on
  output logic             bandgap_en,    // bandgap reference on
  output logic             power_valid    // domain power valid
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // bit 0 rtc clock, 1 oscillator, 2 alarm, 3 wake pin
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic       rtc_prev_reg;
  logic       rtc_rise;
  logic       osc_ok;
  logic       alarm_s;
  logic       wake_s;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg    <= 4'h0;
      sync2_reg    <= 4'h0;
      rtc_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= {wake_pin_i, alarm_irq, osc_enabled, rtc_clk};
      sync2_reg    <= sync1_reg;
      rtc_prev_reg <= sync2_reg[0];
    end
  end

  assign rtc_rise = sync2_reg[0] && !rtc_prev_reg;
  assign osc_ok   = sync2_reg[1];
  assign alarm_s  = sync2_reg[2];
  assign wake_s   = sync2_reg[3];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [rtc_pm_pkg::PM_BITS-1:0] pm_reg;
  logic [rtc_pm_pkg::PM_BITS-1:0] pm_next;
  logic [rtc_pm_pkg::PM_BITS-1:0] pend_data_reg;
  logic [rtc_pm_pkg::PM_BITS-1:0] pend_data_next;
  logic        pend_reg;
  logic        pend_next;
  logic [1:0]  edge_cnt_reg;
  logic [1:0]  edge_cnt_next;
  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;
  logic        access;
  logic        hit_pm;
  logic        hit_status;
  logic        pm_write_ok;
  logic        commit;
  logic        wake_event;
  rtc_pm_pkg::pm_state_e state_reg;
  rtc_pm_pkg::pm_state_e state_next;

  // zero-wait slave: ready rises in the first access cycle
  assign access      = psel && penable && pready;
  assign hit_pm      = paddr == rtc_pm_pkg::PM_REG_ADDR;
  assign hit_status  = paddr == rtc_pm_pkg::STATUS_REG_ADDR;
  assign pm_write_ok = access && pwrite && hit_pm && osc_ok;

  always_comb
  begin
    pready_next  = psel && !penable;
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    if (psel && !penable)
    begin
      if (hit_pm)
      begin
        prdata_next[rtc_pm_pkg::PM_BITS-1:0] = pm_reg; // see R1
        pslverr_next = pwrite && !osc_ok;              // see R13
      end
      else if (hit_status)
      begin
        prdata_next[rtc_pm_pkg::ST_WAKE_BIT]  = wake_s;
        prdata_next[rtc_pm_pkg::ST_PEND_BIT]  = pend_reg;
        prdata_next[rtc_pm_pkg::ST_DOWN_BIT]  =
          state_reg == rtc_pm_pkg::ST_DOWN;
        prdata_next[rtc_pm_pkg::ST_VALID_BIT] = power_valid;
        prdata_next[rtc_pm_pkg::ST_OSC_BIT]   = osc_ok;
        pslverr_next = pwrite;
      end
      else
      begin
        pslverr_next = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // write staging toward the rtc clock
  // ----------------------------------------------------------------
  // a later write replaces a staged one and restarts its count
  assign commit = pend_reg && rtc_rise &&
                  edge_cnt_reg == rtc_pm_pkg::RTC_EDGES_TO_COMMIT - 2'h1;

  always_comb
  begin
    pend_next      = pend_reg;
    pend_data_next = pend_data_reg;
    edge_cnt_next  = edge_cnt_reg;
    pm_next        = pm_reg;
    if (pm_write_ok)
    begin
      pend_next      = 1'b1;                              // see R13
      pend_data_next = pwdata[rtc_pm_pkg::PM_BITS-1:0];   // see R1
      edge_cnt_next  = 2'h0;
    end
    else if (commit)
    begin
      pend_next = 1'b0;
      pm_next   = pend_data_reg;                          // see R13
    end
    else if (pend_reg && rtc_rise)
    begin
      edge_cnt_next = edge_cnt_reg + 2'h1;
    end
    // a wake without a same-cycle commit drops both power-down bits so the domain stays up
    if (wake_event && !commit)
    begin
      pm_next[rtc_pm_pkg::FULL_PD_BIT] = 1'b0;            // see R7
      pm_next[rtc_pm_pkg::REG_PD_BIT]  = 1'b0;            // see R9
    end
  end

  // ----------------------------------------------------------------
  // power sequencer
  // ----------------------------------------------------------------
  logic [31:0] settle_reg;
  logic [31:0] settle_next;
  logic        any_pd;
  logic        wake_pin_ok;

  assign any_pd = pm_reg[rtc_pm_pkg::FULL_PD_BIT] ||
                  pm_reg[rtc_pm_pkg::REG_PD_BIT];
  // an output-configured pin never wakes the domain
  assign wake_pin_ok = wake_s && !pm_reg[rtc_pm_pkg::DIR_BIT]; // see R5 R4
  assign wake_event  = state_reg == rtc_pm_pkg::ST_DOWN &&
                       (wake_pin_ok || alarm_s);

  always_comb
  begin
    state_next  = state_reg;
    settle_next = settle_reg;
    case (state_reg)
      rtc_pm_pkg::ST_RUN:
      begin
        if (any_pd)
        begin
          state_next = rtc_pm_pkg::ST_DOWN;               // see R6 R8
        end
      end
      rtc_pm_pkg::ST_DOWN:
      begin
        if (wake_event)
        begin
          state_next  = rtc_pm_pkg::ST_RAMP;              // see R7 R9
          // the reference needs a long recharge after a full stop
          settle_next = pm_reg[rtc_pm_pkg::FULL_PD_BIT] ?
                        BG_SETTLE : REG_SETTLE;
        end
      end
      rtc_pm_pkg::ST_RAMP:
      begin
        if (settle_reg <= 32'h0000_0001)
        begin
          state_next  = rtc_pm_pkg::ST_RUN;
          settle_next = 32'h0000_0000;
        end
        else
        begin
          settle_next = settle_reg - 32'h0000_0001;
        end
      end
      default:
      begin
        state_next  = rtc_pm_pkg::ST_RUN;
        settle_next = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pm_reg        <= rtc_pm_pkg::PM_RESET[rtc_pm_pkg::PM_BITS-1:0];
      pend_reg      <= 1'b0;
      pend_data_reg <= rtc_pm_pkg::PM_RESET[rtc_pm_pkg::PM_BITS-1:0];
      edge_cnt_reg  <= 2'h0;
      state_reg     <= rtc_pm_pkg::ST_RUN;
      settle_reg    <= 32'h0000_0000;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      wake_pin_o    <= 1'b0;
      wake_pin_oe   <= 1'b0;
      rtc_clk_out   <= 1'b0;
      regulator_en  <= 1'b1;
      analog_por_en <= 1'b1;
      bandgap_en    <= 1'b1;
      power_valid   <= 1'b1;
    end
    else
    begin
      pm_reg        <= pm_next;
      pend_reg      <= pend_next;
      pend_data_reg <= pend_data_next;
      edge_cnt_reg  <= edge_cnt_next;
      state_reg     <= state_next;
      settle_reg    <= settle_next;
      prdata        <= prdata_next;
      pready        <= pready_next;
      pslverr       <= pslverr_next;
      wake_pin_o    <= 1'b0;                              // see R4
      wake_pin_oe   <= pm_reg[rtc_pm_pkg::DIR_BIT] &&
                       !pm_reg[rtc_pm_pkg::DOUT_BIT];      // see R2 R3
      rtc_clk_out   <= pm_reg[rtc_pm_pkg::CLKOUT_BIT] &&
                       sync2_reg[0];                       // see R11
      regulator_en  <= state_next != rtc_pm_pkg::ST_DOWN; // see R6 R8
      analog_por_en <= state_next != rtc_pm_pkg::ST_DOWN; // see R6 R8
      bandgap_en    <= !(state_next == rtc_pm_pkg::ST_DOWN &&
                         pm_next[rtc_pm_pkg::FULL_PD_BIT]); // see R6 R8
      power_valid   <= state_next == rtc_pm_pkg::ST_RUN;  // see R12
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pm_write;
    pm_write_ok && !pend_reg;
  endsequence

  sequence s_no_commit_yet;
    !commit [*1];
  endsequence

  a_reserved_bits: assert property ( // see R1
    (pready && psel && penable && !pwrite && hit_pm)
    |-> prdata[31:rtc_pm_pkg::PM_BITS] == '0)
    else $error("reserved bits of power register read nonzero");

  a_wake_drive: assert property ( // see R2
    (pm_reg[rtc_pm_pkg::DIR_BIT] && !pm_reg[rtc_pm_pkg::DOUT_BIT])
    |=> (wake_pin_oe && !wake_pin_o))
    else $error("wake pin not pulled low when asked");

  a_wake_input: assert property ( // see R3
    !pm_reg[rtc_pm_pkg::DIR_BIT] |=> !wake_pin_oe)
    else $error("wake pin driven while configured as input");

  a_wake_gated: assert property ( // see R5
    (state_reg == rtc_pm_pkg::ST_DOWN && pm_reg[rtc_pm_pkg::DIR_BIT] &&
     !alarm_s)
    |=> state_reg == rtc_pm_pkg::ST_DOWN)
    else $error("output wake pin woke the domain");

  a_full_down: assert property ( // see R6
    (state_reg == rtc_pm_pkg::ST_RUN && pm_reg[rtc_pm_pkg::FULL_PD_BIT])
    |=> (!regulator_en && !analog_por_en && !bandgap_en))
    else $error("full power-down left a supply running");

  a_reg_down: assert property ( // see R8
    (state_reg == rtc_pm_pkg::ST_RUN && pm_reg[rtc_pm_pkg::REG_PD_BIT] &&
     !pm_reg[rtc_pm_pkg::FULL_PD_BIT])
    |=> (!regulator_en && !analog_por_en && bandgap_en))
    else $error("regulator power-down handled the reference wrongly");

  a_wake_resume: assert property ( // see R7 R9
    wake_event |=> (regulator_en && analog_por_en && bandgap_en
                    && !power_valid))
    else $error("wake did not re-enable the supplies");

  a_clkout_gate: assert property ( // see R11
    !pm_reg[rtc_pm_pkg::CLKOUT_BIT] |=> !rtc_clk_out)
    else $error("clock output active while disabled");

  a_valid_low: assert property ( // see R12
    (state_reg != rtc_pm_pkg::ST_RUN) |-> !power_valid)
    else $error("power valid high while powered down");

  a_write_delay: assert property ( // see R13
    s_pm_write ##1 s_no_commit_yet |-> pm_reg == $past(pm_reg, 1)
                                      || $past(wake_event))
    else $error("write landed before two rtc edges");

  a_write_blocked: assert property ( // see R13
    (access && pwrite && hit_pm && !osc_ok && !pend_reg) |=> !pend_reg)
    else $error("write staged while oscillator stopped");

endmodule : rtc_power_management_ctrl

// >>> verification/wake_pin_partner.sv
// external power management circuit seen on the wake pin
`timescale 1ns/100ps
module wake_pin_partner (
  input  wire logic wake_pin_o,  // device drive value
  input  wire logic wake_pin_oe, // device pulls the pin
  input  wire logic drive_en,    // circuit drives the pin
  input  wire logic drive_high,  // level the circuit drives
  output logic      wake_line    // resolved pin level
);
  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // device only ever pulls low; an idle pin floats up to the pull-up
  assign wake_line = wake_pin_oe ? wake_pin_o
                   : (drive_en ? drive_high : 1'b1);
endmodule : wake_pin_partner

// >>> verification/rtc_power_management_ctrl_test.sv
// self-checking bench of the rtc power management control block
`timescale 1ns/100ps
module rtc_power_management_ctrl_test;
  localparam logic [15:0] PM = rtc_pm_pkg::PM_REG_ADDR;
  localparam logic [15:0] ST = rtc_pm_pkg::STATUS_REG_ADDR;
  logic        pclk, presetn, psel, penable, pwrite, rtc_clk;
  logic        osc_enabled, alarm_irq, drive_en, drive_high, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        pready, pslverr, wake_line, wake_pin_o, wake_pin_oe;
  logic        rtc_clk_out, regulator_en, analog_por_en;
  logic        bandgap_en, power_valid;
  integer      err_count, total_checks, pm_model, i, hits;

  rtc_power_management_ctrl #(.BG_SETTLE(20), .REG_SETTLE(16)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk(rtc_clk), .osc_enabled(osc_enabled), .alarm_irq(alarm_irq),
    .wake_pin_i(wake_line), .wake_pin_o(wake_pin_o),
    .wake_pin_oe(wake_pin_oe), .rtc_clk_out(rtc_clk_out),
    .regulator_en(regulator_en), .analog_por_en(analog_por_en),
    .bandgap_en(bandgap_en), .power_valid(power_valid));

  wake_pin_partner u_partner (
    .wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe),
    .drive_en(drive_en), .drive_high(drive_high), .wake_line(wake_line));

  // ----------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // rtc clock scaled down to 40 bus cycles to keep the run short
  // one process owns the rtc clock so it has a single driver
  initial
  begin
    rtc_clk = 1'b0;
    forever
    begin
      repeat (20) @(posedge pclk);
      rtc_clk <= ~rtc_clk;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task summarize;
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(pready, 1'b1);
    if (pready !== 1'b1)
      summarize;
  endtask : apb

  function logic sig(input integer k);
    case (k)
      0: return regulator_en;
      1: return bandgap_en;
      2: return power_valid;
      default: return rtc_clk_out;
    endcase
  endfunction : sig

  task wait_sig(input integer k, input logic v);
    integer n;
    n = 0;
    while (sig(k) !== v && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk(sig(k), v);
    if (sig(k) !== v)
      summarize;
  endtask : wait_sig

  task pm_write(input logic [31:0] d);
    integer n;
    apb(1'b1, PM, d);
    chk(er, 1'b0);
    apb(1'b0, PM, 0);
    chk(rd, pm_model);
    n = 0;
    do
    begin
      apb(1'b0, ST, 0);
      n++;
    end
    while (rd[1] !== 1'b0 && n < 60);
    chk(rd[1], 1'b0);
    pm_model = d & 32'h0000_001F;
    apb(1'b0, PM, 0);
    chk(rd, pm_model);
  endtask : pm_write

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {alarm_irq, drive_high, er, rd} = '0;
    {osc_enabled, drive_en} = 2'b11;
    {err_count, total_checks, pm_model, hits} = '0;
    seed = 32'h8FEE;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, PM, 0);
    chk(rd, rtc_pm_pkg::PM_RESET);
    chk({regulator_en, analog_por_en, bandgap_en, power_valid}, 4'hF);
    pm_write(32'hFFFF_FFE1);
    wait_sig(3, 1'b1);
    wait_sig(3, 1'b0);
    pm_write(32'h0000_0000);
    repeat (100)
    begin
      @(posedge pclk);
      hits += rtc_clk_out;
    end
    chk(hits, 0);
    // open-drain output: the circuit lets go so the pull-up shows
    drive_en <= 1'b0;
    pm_write(32'h0000_0008);
    chk({wake_pin_oe, wake_line}, 2'b10);
    pm_write(32'h0000_0018);
    chk({wake_pin_oe, wake_line}, 2'b01);
    // regulators are in use, so power-down is allowed
    pm_write(32'h0000_001A);
    wait_sig(0, 1'b0);
    chk({analog_por_en, bandgap_en, power_valid}, 3'b010);
    drive_en   <= 1'b1;
    drive_high <= 1'b1;
    repeat (60) @(posedge pclk);
    drive_high <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(regulator_en, 1'b0);
    alarm_irq <= 1'b1;
    wait_sig(0, 1'b1);
    alarm_irq <= 1'b0;
    chk({analog_por_en, power_valid}, 2'b10);
    wait_sig(2, 1'b1);
    pm_model = pm_model & 32'h19;
    apb(1'b0, PM, 0);
    chk(rd, pm_model);
    pm_write(32'h0000_0004);
    wait_sig(1, 1'b0);
    chk({regulator_en, analog_por_en, power_valid}, 3'b000);
    drive_high <= 1'b1;
    wait_sig(1, 1'b1);
    drive_high <= 1'b0;
    chk({regulator_en, power_valid}, 2'b10);
    wait_sig(2, 1'b1);
    pm_model = 0;
    apb(1'b0, PM, 0);
    chk(rd, pm_model);
    apb(1'b0, 16'h1938, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, ST, 32'h1F);
    chk(er, 1'b1);
    osc_enabled <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, PM, 32'h01);
    chk(er, 1'b1);
    osc_enabled <= 1'b1;
    repeat (100) @(posedge pclk);
    apb(1'b0, PM, 0);
    chk(rd, pm_model);
    for (i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      pm_write(seed & 32'hFFFF_FFF9);
      chk(wake_pin_oe, seed[3] & ~seed[4]);
    end
    summarize;
  end
endmodule : rtc_power_management_ctrl_test
